// ### rtl/dps_pkg.sv
package dps_pkg;
  // register byte offsets (parameter set layout)
  localparam logic [7:0] DPS_OFF_OPTIONS   = 8'h00;
  localparam logic [7:0] DPS_OFF_SRC_START = 8'h04;
  localparam logic [7:0] DPS_OFF_COUNTS    = 8'h08;
  localparam logic [7:0] DPS_OFF_DST_START = 8'h0C;
  localparam logic [7:0] DPS_OFF_ASTEP     = 8'h10;
  localparam logic [7:0] DPS_OFF_LINK      = 8'h14;
  localparam logic [7:0] DPS_OFF_FSTEP     = 8'h18;
  localparam logic [7:0] DPS_OFF_FRAMES    = 8'h1C;
  localparam logic [7:0] DPS_OFF_CONTROL   = 8'h20;
  localparam logic [7:0] DPS_OFF_STATUS    = 8'h24;
  localparam logic [7:0] DPS_OFF_LINKADDR  = 8'h28;
  // field positions
  localparam int DPS_OPT_SRC_MODE_BIT = 0;
  localparam int DPS_OPT_DST_MODE_BIT = 1;
  localparam int DPS_OPT_SYNC_DIM_BIT = 2;
  localparam int DPS_CTL_EVENT_BIT    = 0;
  localparam int DPS_HALF_LO          = 0;
  localparam int DPS_HALF_HI          = 16;
  localparam int DPS_HALF_W           = 16;
  // special values and reset values
  localparam logic [15:0] DPS_NULL_LINK    = 16'hFFFF;
  localparam logic [4:0]  DPS_LINK_ALIGN0  = 5'h00;
  localparam logic [31:0] DPS_WORD_RESET   = 32'h0000_0000;
  localparam logic [31:0] DPS_UNMAPPED_RD  = 32'h0000_0000;
  localparam int          DPS_FIFO_DEPTH   = 8;
  localparam int          DPS_LINK_SLOTS   = 4;
  typedef enum logic [2:0] {
    DPS_IDLE  = 3'b000,
    DPS_EMIT  = 3'b001,
    DPS_STEP  = 3'b010,
    DPS_LINK  = 3'b011,
    DPS_DONE  = 3'b100
  } dps_state_t;
endpackage

// ### rtl/dps_fifo.sv
`timescale 1ns/1ps
module dps_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;
  assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data  = mem_reg[rd_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  // storage
  always_ff @(posedge i_sys_clk)
  begin
    if (push) mem_reg[wr_reg] <= i_in_data;
  end
  // pointers and fill level
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push) wr_reg <= wr_reg + AW'(1);
      if (pop) rd_reg <= rd_reg + AW'(1);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // dps_fifo

// ### rtl/dps_slot_mem.sv
`timescale 1ns/1ps
module dps_slot_mem
  import dps_pkg::*;
#(
  parameter int SLOTS = 4
) (
  // clock
  input  wire logic        i_sys_clk,
  // write port
  input  wire logic        i_we,
  input  wire logic [15:0] i_waddr,
  input  wire logic [31:0] i_wdata,
  // read port
  input  wire logic [15:0] i_raddr,
  output logic      [31:0] o_rdata
);
  localparam int SW = $clog2(SLOTS);
  initial
  begin
    if (SLOTS < 2 || (1 << SW) != SLOTS || SW > 6) $error("slots must be a power of two, 2 to 64");
  end
  logic [31:0] mem_reg [SLOTS*8];
  logic [SW+2:0] wi;
  logic [SW+2:0] ri;
  assign wi      = i_waddr[SW+4:2];
  assign ri      = i_raddr[SW+4:2];
  assign o_rdata = mem_reg[ri];
  always_ff @(posedge i_sys_clk)
  begin
    if (i_we) mem_reg[wi] <= i_wdata;
  end
endmodule // dps_slot_mem

// ### rtl/dps_parameter_memory_set.sv
`timescale 1ns/1ps
// Contract
// - source start word is the byte address of the first read byte
// - destination start word is the byte address of the first written byte
// - counts word low half is bytes per array
// - counts word high half is arrays per frame
// - array step high half offsets destination between arrays
// - array step low half offsets source between arrays
// - all four steps are 16-bit two's complement, sign extended
// - arrays-per-frame reloads from reload field after last array of frame
// - link half addresses the set copied in once current set exhausted
// - link value all ones means no further set
// - frame step high half offsets destination between frames
// - frame step low half offsets source between frames
// - frames word low half is frames per block
// - sync dimension 0 moves one array per event, 1 a frame
// - address mode 0 increments addresses byte by byte in an array
module dps_parameter_memory_set
  import dps_pkg::*;
#(
  parameter int FIFO_DEPTH = DPS_FIFO_DEPTH,
  parameter int LINK_SLOTS = DPS_LINK_SLOTS
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic      [31:0] o_prdata,
  output logic             o_pslverr,
  // transfer request stream
  output logic             o_req_valid,
  input  wire logic        i_req_ready,
  output logic      [31:0] o_req_src,
  output logic      [31:0] o_req_dst,
  output logic      [15:0] o_req_bytes,
  output logic             o_req_src_fixed,
  output logic             o_req_dst_fixed,
  // status
  output logic             o_busy,
  output logic             o_set_done
);
  initial
  begin
    if (FIFO_DEPTH < 2) $error("fifo depth too small");
  end
  logic [31:0] options_reg;
  logic [31:0] source_start_address_reg;
  logic [31:0] array_and_frame_counts_reg;
  logic [31:0] destination_start_address_reg;
  logic [31:0] array_step_offsets_reg;
  logic [31:0] next_set_and_count_reload_reg;
  logic [31:0] frame_step_offsets_reg;
  logic [31:0] frames_per_block_reg;
  logic [31:0] link_area_addr_reg;
  dps_state_t  state_reg;
  logic [31:0] arr_src_reg;
  logic [31:0] arr_dst_reg;
  logic [31:0] frm_src_reg;
  logic [31:0] frm_dst_reg;
  logic [15:0] arrays_left_reg;
  logic [15:0] frames_left_reg;
  logic        pending_reg;
  logic [2:0]  link_idx_reg;
  logic [15:0] link_base_reg;
  logic        done_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  logic        ctl_event;
  logic        area_we;
  logic [31:0] area_rdata;
  logic        fifo_ready;
  logic        fifo_valid;
  logic [81:0] fifo_out;
  logic        emit;
  logic [15:0] array_byte_count;
  logic [15:0] arrays_per_frame_reload;
  logic [15:0] next_link;
  logic        sync_dimension;
  logic [31:0] source_array_step;
  logic [31:0] destination_array_step;
  logic [31:0] source_frame_step;
  logic [31:0] destination_frame_step;
  logic        last_array;
  logic        last_frame;
  logic [15:0] link_word_addr;

  assign array_byte_count        = array_and_frame_counts_reg[DPS_HALF_LO +: DPS_HALF_W];
  assign arrays_per_frame_reload = next_set_and_count_reload_reg[DPS_HALF_HI +: DPS_HALF_W];
  assign next_link               = next_set_and_count_reload_reg[DPS_HALF_LO +: DPS_HALF_W];
  assign sync_dimension          = options_reg[DPS_OPT_SYNC_DIM_BIT];
  assign source_array_step       = {{16{array_step_offsets_reg[15]}}, array_step_offsets_reg[15:0]};
  assign destination_array_step  = {{16{array_step_offsets_reg[31]}}, array_step_offsets_reg[31:16]};
  assign source_frame_step       = {{16{frame_step_offsets_reg[15]}}, frame_step_offsets_reg[15:0]};
  assign destination_frame_step  = {{16{frame_step_offsets_reg[31]}}, frame_step_offsets_reg[31:16]};
  assign last_array              = (arrays_left_reg == 16'h0001);
  assign last_frame              = (frames_left_reg == 16'h0001);
  assign link_word_addr          = link_base_reg + {8'h00, 3'b000, link_idx_reg, 2'b00};

  // apb decode
  assign wr_acc    = i_psel & i_penable & i_pwrite & ~pready_reg;
  assign rd_acc    = i_psel & i_penable & ~i_pwrite & ~pready_reg;
  assign mapped    = (i_paddr[11:8] == 4'h0) && (i_paddr[7:0] <= DPS_OFF_LINKADDR) && (i_paddr[1:0] == 2'b00);
  assign ctl_event = wr_acc && i_paddr[7:0] == DPS_OFF_CONTROL && i_pwdata[DPS_CTL_EVENT_BIT];
  assign area_we   = i_psel & i_penable & i_pwrite & ~pready_reg & i_paddr[11];
  assign emit      = (state_reg == DPS_EMIT) && fifo_ready;

  // linked set storage
  dps_slot_mem #(
    .SLOTS (LINK_SLOTS)
  ) u_slots (
    .i_sys_clk (i_sys_clk),
    .i_we      (area_we),
    .i_waddr   ({5'h00, i_paddr[10:0]}),
    .i_wdata   (i_pwdata),
    .i_raddr   (state_reg == DPS_LINK ? link_word_addr : {5'h00, i_paddr[10:0]}),
    .o_rdata   (area_rdata)
  );

  // request buffer
  dps_fifo #(
    .WIDTH (82),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (emit),
    .o_in_ready  (fifo_ready),
    // addresses and byte count of one array
    .i_in_data   ({options_reg[DPS_OPT_DST_MODE_BIT], options_reg[DPS_OPT_SRC_MODE_BIT],
                   array_byte_count, arr_dst_reg, arr_src_reg}),
    .o_out_valid (fifo_valid),
    .i_out_ready (i_req_ready | ~o_req_valid),
    .o_out_data  (fifo_out)
  );

  // request output stage
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_req_valid     <= 1'b0;
      o_req_src       <= '0;
      o_req_dst       <= '0;
      o_req_bytes     <= '0;
      o_req_src_fixed <= 1'b0;
      o_req_dst_fixed <= 1'b0;
    end
    else if (i_req_ready | ~o_req_valid)
    begin
      o_req_valid     <= fifo_valid;
      o_req_src       <= fifo_out[31:0];
      o_req_dst       <= fifo_out[63:32];
      o_req_bytes     <= fifo_out[79:64];
      o_req_src_fixed <= fifo_out[80];
      o_req_dst_fixed <= fifo_out[81];
    end
  end

  // apb response
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= DPS_WORD_RESET;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= i_psel & i_penable & ~pready_reg;
      pslverr_reg <= (wr_acc | rd_acc) & ~mapped & ~i_paddr[11];
      if (rd_acc)
      begin
        if (i_paddr[11]) prdata_reg <= area_rdata;
        else
        begin
          case (i_paddr[7:0])
            DPS_OFF_OPTIONS:   prdata_reg <= options_reg;
            DPS_OFF_SRC_START: prdata_reg <= source_start_address_reg;
            DPS_OFF_COUNTS:    prdata_reg <= array_and_frame_counts_reg;
            DPS_OFF_DST_START: prdata_reg <= destination_start_address_reg;
            DPS_OFF_ASTEP:     prdata_reg <= array_step_offsets_reg;
            DPS_OFF_LINK:      prdata_reg <= next_set_and_count_reload_reg;
            DPS_OFF_FSTEP:     prdata_reg <= frame_step_offsets_reg;
            DPS_OFF_FRAMES:    prdata_reg <= frames_per_block_reg;
            DPS_OFF_STATUS:    prdata_reg <= {29'h0, pending_reg, done_reg, state_reg != DPS_IDLE};
            DPS_OFF_LINKADDR:  prdata_reg <= link_area_addr_reg;
            default:           prdata_reg <= DPS_UNMAPPED_RD;
          endcase
        end
      end
    end
  end
  assign o_pready  = pready_reg;
  assign o_prdata  = prdata_reg;
  assign o_pslverr = pslverr_reg;

  // parameter set words, written by software or updated while running
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      options_reg                   <= DPS_WORD_RESET;
      source_start_address_reg      <= DPS_WORD_RESET;
      array_and_frame_counts_reg    <= DPS_WORD_RESET;
      destination_start_address_reg <= DPS_WORD_RESET;
      array_step_offsets_reg        <= DPS_WORD_RESET;
      next_set_and_count_reload_reg <= {DPS_WORD_RESET[31:16], DPS_NULL_LINK};
      frame_step_offsets_reg        <= DPS_WORD_RESET;
      frames_per_block_reg          <= DPS_WORD_RESET;
      link_area_addr_reg            <= DPS_WORD_RESET;
    end
    else if (state_reg == DPS_LINK)
    begin
      // copy linked set one word per cycle
      case (link_idx_reg)
        3'd0: options_reg                   <= area_rdata;
        3'd1: source_start_address_reg      <= area_rdata;
        3'd2: array_and_frame_counts_reg    <= area_rdata;
        3'd3: destination_start_address_reg <= area_rdata;
        3'd4: array_step_offsets_reg        <= area_rdata;
        3'd5: next_set_and_count_reload_reg <= area_rdata;
        3'd6: frame_step_offsets_reg        <= area_rdata;
        default: frames_per_block_reg       <= {16'h0000, area_rdata[15:0]};
      endcase
    end
    else if (wr_acc && state_reg == DPS_IDLE)
    begin
      case (i_paddr[7:0])
        DPS_OFF_OPTIONS:   options_reg                   <= i_pwdata;
        DPS_OFF_SRC_START: source_start_address_reg      <= i_pwdata;
        DPS_OFF_COUNTS:    array_and_frame_counts_reg    <= i_pwdata;
        DPS_OFF_DST_START: destination_start_address_reg <= i_pwdata;
        DPS_OFF_ASTEP:     array_step_offsets_reg        <= i_pwdata;
        DPS_OFF_LINK:      next_set_and_count_reload_reg <= i_pwdata;
        DPS_OFF_FSTEP:     frame_step_offsets_reg        <= i_pwdata;
        DPS_OFF_FRAMES:    frames_per_block_reg          <= {16'h0000, i_pwdata[15:0]};
        DPS_OFF_LINKADDR:  link_area_addr_reg            <= i_pwdata;
        default:           options_reg                   <= options_reg;
      endcase
    end
  end

  // event latch, set wins over consumption
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst) pending_reg <= 1'b0;
    else if (ctl_event) pending_reg <= 1'b1;
    else if (state_reg == DPS_IDLE && pending_reg) pending_reg <= 1'b0;
  end

  // sequencer
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg       <= DPS_IDLE;
      arr_src_reg     <= '0;
      arr_dst_reg     <= '0;
      frm_src_reg     <= '0;
      frm_dst_reg     <= '0;
      arrays_left_reg <= '0;
      frames_left_reg <= '0;
      link_idx_reg    <= '0;
      link_base_reg   <= DPS_NULL_LINK;
      done_reg        <= 1'b0;
    end
    else
    begin
      case (state_reg)
        DPS_IDLE:
        begin
          if (pending_reg)
          begin
            done_reg <= 1'b0;
            if (frames_left_reg == 16'h0000)
            begin
              // fresh set starts at its base
              arr_src_reg     <= source_start_address_reg;
              arr_dst_reg     <= destination_start_address_reg;
              frm_src_reg     <= source_start_address_reg;
              frm_dst_reg     <= destination_start_address_reg;
              arrays_left_reg <= array_and_frame_counts_reg[DPS_HALF_HI +: DPS_HALF_W];
              frames_left_reg <= frames_per_block_reg[DPS_HALF_LO +: DPS_HALF_W];
            end
            state_reg <= DPS_EMIT;
          end
        end
        DPS_EMIT:
        begin
          if (emit) state_reg <= DPS_STEP;
        end
        DPS_STEP:
        begin
          if (!last_array)
          begin
            arr_src_reg     <= arr_src_reg + source_array_step;
            arr_dst_reg     <= arr_dst_reg + destination_array_step;
            arrays_left_reg <= arrays_left_reg - 16'h0001;
            // one array per event unless frame synchronised
            state_reg       <= sync_dimension ? DPS_EMIT : DPS_IDLE;
          end
          else if (!last_frame)
          begin
            arr_src_reg     <= frm_src_reg + source_frame_step;
            arr_dst_reg     <= frm_dst_reg + destination_frame_step;
            frm_src_reg     <= frm_src_reg + source_frame_step;
            frm_dst_reg     <= frm_dst_reg + destination_frame_step;
            arrays_left_reg <= arrays_per_frame_reload;
            frames_left_reg <= frames_left_reg - 16'h0001;
            state_reg       <= DPS_IDLE;
          end
          else
          begin
            frames_left_reg <= 16'h0000;
            arrays_left_reg <= 16'h0000;
            done_reg        <= 1'b1;
            link_idx_reg    <= 3'd0;
            link_base_reg   <= next_link;
            state_reg       <= (next_link == DPS_NULL_LINK) ? DPS_DONE : DPS_LINK;
          end
        end
        DPS_LINK:
        begin
          link_idx_reg <= link_idx_reg + 3'd1;
          if (link_idx_reg == 3'd7) state_reg <= DPS_DONE;
        end
        DPS_DONE:
        begin
          state_reg <= DPS_IDLE;
        end
        default:
        begin
          state_reg <= DPS_IDLE;
        end
      endcase
    end
  end

  // status outputs
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_busy     <= 1'b0;
      o_set_done <= 1'b0;
    end
    else
    begin
      o_busy     <= (state_reg != DPS_IDLE) | pending_reg;
      o_set_done <= (state_reg == DPS_DONE);
    end
  end
endmodule // dps_parameter_memory_set

// ### testbench/dps_parameter_memory_set_asserts.sv
`timescale 1ns/1ps
module dps_parameter_memory_set_asserts
  import dps_pkg::*;
(
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // request stream
  input wire logic        o_req_valid,
  input wire logic        i_req_ready,
  input wire logic [31:0] o_req_src,
  input wire logic [31:0] o_req_dst,
  input wire logic [15:0] o_req_bytes,
  input wire logic        o_req_src_fixed,
  input wire logic        o_req_dst_fixed,
  // status
  input wire logic        o_set_done
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_pready_one:
    assert property (o_pready |=> !o_pready) else $error("pready too long");
  a_pready_wait:
    assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("pready late");
  a_pready_cause:
    assert property (o_pready |-> $past(i_psel && i_penable)) else $error("pready without access");
  a_slverr_ready:
    assert property (o_pslverr |-> o_pready) else $error("slverr without pready");
  a_req_addr_hold:
    assert property (o_req_valid && !i_req_ready |=> o_req_valid && $stable(o_req_src) && $stable(o_req_dst))
      else $error("request address changed");
  a_req_len_hold:
    assert property (o_req_valid && !i_req_ready |=> $stable(o_req_bytes) && $stable(o_req_src_fixed)
      && $stable(o_req_dst_fixed)) else $error("request length changed");
  a_req_len_nonzero:
    assert property (o_req_valid |-> o_req_bytes != 16'h0000) else $error("zero length request");
  a_done_one:
    assert property (o_set_done |=> !o_set_done) else $error("done too long");
endmodule // dps_parameter_memory_set_asserts

bind dps_parameter_memory_set dps_parameter_memory_set_asserts dps_parameter_memory_set_asserts_i (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_req_valid(o_req_valid), .i_req_ready(i_req_ready),
  .o_req_src(o_req_src), .o_req_dst(o_req_dst), .o_req_bytes(o_req_bytes),
  .o_req_src_fixed(o_req_src_fixed), .o_req_dst_fixed(o_req_dst_fixed), .o_set_done(o_set_done));

// ### testbench/dps_req_sink.sv
`timescale 1ns/1ps
module dps_req_sink (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  // request stream
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  input  wire logic [31:0] i_req_src,
  input  wire logic [31:0] i_req_dst,
  input  wire logic [15:0] i_req_bytes,
  input  wire logic        i_req_src_fixed,
  input  wire logic        i_req_dst_fixed,
  // bench control
  input  wire logic        i_stall
);
  logic [31:0] q_src[$];
  logic [31:0] q_dst[$];
  logic [15:0] q_len[$];
  logic [1:0]  q_mode[$];
  // one whole request taken per accepting edge
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_req_ready <= 1'b0;
    end
    else
    begin
      o_req_ready <= !i_stall;
      if (i_req_valid && o_req_ready)
      begin
        q_src.push_back(i_req_src);
        q_dst.push_back(i_req_dst);
        q_len.push_back(i_req_bytes);
        q_mode.push_back({i_req_dst_fixed, i_req_src_fixed});
      end
    end
  end
endmodule // dps_req_sink

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dps_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} dps_row_t;
  logic        i_sys_clk = 1'b0;
  logic        i_rst     = 1'b1;
  logic        i_psel    = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite  = 1'b0;
  logic [11:0] i_paddr   = 12'h000;
  logic [31:0] i_pwdata  = 32'h0;
  logic        stall     = 1'b0;
  logic        o_pready, o_pslverr, o_req_valid, i_req_ready, o_req_src_fixed, o_req_dst_fixed, o_busy, o_set_done;
  logic [31:0] o_prdata, o_req_src, o_req_dst, rdat;
  logic [15:0] o_req_bytes;
  logic        rerr;
  logic [31:0] s[8];
  logic [31:0] s2[8];
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          dones = 0;
  dps_row_t    rows[12];

  dps_parameter_memory_set dps_parameter_memory_set_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_req_valid(o_req_valid),
    .i_req_ready(i_req_ready), .o_req_src(o_req_src), .o_req_dst(o_req_dst), .o_req_bytes(o_req_bytes),
    .o_req_src_fixed(o_req_src_fixed), .o_req_dst_fixed(o_req_dst_fixed), .o_busy(o_busy),
    .o_set_done(o_set_done));
  dps_req_sink dps_req_sink_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(o_req_valid),
    .o_req_ready(i_req_ready), .i_req_src(o_req_src), .i_req_dst(o_req_dst), .i_req_bytes(o_req_bytes),
    .i_req_src_fixed(o_req_src_fixed), .i_req_dst_fixed(o_req_dst_fixed), .i_stall(stall));

  always #25 i_sys_clk = ~i_sys_clk;

  task close_out;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge i_sys_clk)
  begin
    cyc <= cyc + 1;
    if (o_set_done === 1'b1)
      dones <= dones + 1;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task prog(input logic [11:0] b, input logic [31:0] v[8]);
    for (int k = 0; k < 8; k++)
      apb(1'b1, b + 12'(4 * k), v[k]);
  endtask

  task wait_q(input int n);
    int t;
    t = 0;
    while (dps_req_sink_i.q_src.size() < n && t < 400)
    begin
      @(posedge i_sys_clk);
      t++;
    end
    repeat (12) @(posedge i_sys_clk);
    chk("requests", n, dps_req_sink_i.q_src.size());
  endtask

  task fire(input int n);
    apb(1'b1, DPS_OFF_CONTROL, 32'h0000_0001);
    wait_q(n);
  endtask

  function logic [31:0] sx(input logic [15:0] h);
    return {{16{h[15]}}, h};
  endfunction

  task verify(input logic [31:0] v[8]);
    for (int f = 0; f < v[7][15:0]; f++)
      for (int a = 0; a < v[2][31:16]; a++)
      begin
        chk("src", v[1] + sx(v[4][15:0]) * a + sx(v[6][15:0]) * f, dps_req_sink_i.q_src.pop_front());
        chk("dst", v[3] + sx(v[4][31:16]) * a + sx(v[6][31:16]) * f, dps_req_sink_i.q_dst.pop_front());
        chk("bytes", {16'h0, v[2][15:0]}, {16'h0, dps_req_sink_i.q_len.pop_front()});
        chk("mode", {30'h0, v[0][1:0]}, {30'h0, dps_req_sink_i.q_mode.pop_front()});
      end
  endtask

  initial
  begin
    rows = '{'{12'h004, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 1'b0}, '{12'h008, 32'h0003_0004, 32'h0003_0004, 1'b0},
             '{12'h00C, 32'hFFFF_0000, 32'hFFFF_0000, 1'b0}, '{12'h010, 32'h8000_7FFF, 32'h8000_7FFF, 1'b0},
             '{12'h014, 32'h0003_FFFF, 32'h0003_FFFF, 1'b0}, '{12'h018, 32'h0001_FFFF, 32'h0001_FFFF, 1'b0},
             '{12'h01C, 32'h0000_0002, 32'h0000_0002, 1'b0}, '{12'h030, 32'h0000_1234, 32'h0, 1'b1},
             '{12'h002, 32'h0000_5678, 32'h0, 1'b1}, '{12'h000, 32'h0000_0003, 32'h0000_0003, 1'b0},
             '{12'h028, 32'h1234_5678, 32'h1234_5678, 1'b0}, '{12'h024, 32'h0000_0007, 32'h0, 1'b0}};
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    apb(1'b0, DPS_OFF_LINK, 32'h0);
    chk("link reset", 32'h0000_FFFF, rdat);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      chk("read", rows[i].r, rdat);
      chk("slverr", {31'h0, rows[i].e}, {31'h0, rerr});
    end
    // frame per event, negative steps, null link
    s = '{32'h4, 32'h1000, 32'h0003_0004, 32'h2000, 32'hFFF8_0010, 32'h0003_FFFF, 32'hFFF0_0100, 32'h2};
    prog(12'h000, s);
    fire(3);
    chk("done early", 0, dones);
    fire(6);
    chk("done", 1, dones);
    apb(1'b0, DPS_OFF_STATUS, 32'h0);
    chk("status done", 32'h0000_0002, rdat);
    verify(s);
    apb(1'b0, DPS_OFF_SRC_START, 32'h0);
    chk("null link", s[1], rdat);
    // array per event, reload, step extremes, fixed modes
    s = '{32'h3, 32'h8000_0000, 32'h0002_0010, 32'hFFFF_FFF0, 32'h0020_0040, 32'h0002_FFFF, 32'h7FFF_8000, 32'h2};
    prog(12'h000, s);
    for (int k = 1; k <= 4; k++)
      fire(k);
    verify(s);
    // link to slot one
    s2 = '{32'h0, 32'h3000, 32'h0001_0008, 32'h4000, 32'h0, 32'h0001_FFFF, 32'h0, 32'h1};
    s = '{32'h4, 32'h5000, 32'h0001_0008, 32'h6000, 32'h0, 32'h0001_0020, 32'h0, 32'h1};
    prog(12'h820, s2);
    prog(12'h000, s);
    fire(1);
    verify(s);
    apb(1'b0, DPS_OFF_SRC_START, 32'h0);
    chk("linked src", s2[1], rdat);
    apb(1'b0, DPS_OFF_LINK, 32'h0);
    chk("linked link", s2[5], rdat);
    fire(1);
    verify(s2);
    // far side stalls until the buffer refuses
    s = '{32'h4, 32'h100, 32'h000C_0002, 32'h200, 32'h0002_0002, 32'h000C_FFFF, 32'h0, 32'h1};
    prog(12'h000, s);
    stall <= 1'b1;
    apb(1'b1, DPS_OFF_CONTROL, 32'h0000_0001);
    repeat (40) @(posedge i_sys_clk);
    chk("valid held", 1, o_req_valid);
    chk("busy", 1, o_busy);
    apb(1'b1, DPS_OFF_SRC_START, 32'hDEAD_BEEF);
    stall <= 1'b0;
    wait_q(12);
    apb(1'b0, DPS_OFF_SRC_START, 32'h0);
    chk("refused write", s[1], rdat);
    verify(s);
    // second reset while idle, after the run has finished
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    chk("busy in reset", 0, o_busy);
    chk("valid in reset", 0, o_req_valid);
    i_rst <= 1'b0;
    apb(1'b0, DPS_OFF_LINK, 32'h0);
    chk("link reset", 32'h0000_FFFF, rdat);
    close_out();
  end
endmodule // testbench
